// ---- logic/conf_pkg.sv ----
package conf_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_PARTIES = 15;
  localparam int NUM_CONFS = 5;
  localparam int SAMPLE_W = 16;
  localparam int SUM_W = 21;

  // ****************************************************************
  // register map and fields
  // ****************************************************************
  localparam logic [7:0] PARTY_BASE_ADDR = 8'h30;
  localparam logic [7:0] PARTY_LAST_ADDR = 8'h3e;
  localparam logic [7:0] OVF_STATUS_ADDR = 8'h08;
  localparam logic [7:0] PARTY_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int ID_MSB = 7;
  localparam int ID_LSB = 5;
  localparam int ST_BIT = 3;
  localparam int IT_BIT = 2;
  localparam int GAIN_MSB = 1;
  localparam int GAIN_LSB = 0;
  localparam logic [2:0] CONF_NONE = 3'h0;
  localparam logic [2:0] CONF_LAST = 3'h5;
  localparam logic [2:0] CONF_CLEAR_ALL = 3'h7;

  // tone duration counted in frames
  localparam logic [15:0] TONE_FRAMES_DEFAULT = 16'h0320;

  // ****************************************************************
  // levels: 0, -3, -6, -9 db as q8 factors
  // ****************************************************************
  localparam logic [8:0] Q8_0DB = 9'h100;
  localparam logic [8:0] Q8_3DB = 9'h0b5;
  localparam logic [8:0] Q8_6DB = 9'h080;
  localparam logic [8:0] Q8_9DB = 9'h05b;
  localparam logic signed [SUM_W-1:0] SAT_MAX = 21'sh007fff;
  localparam logic signed [SUM_W-1:0] SAT_MIN = -21'sh008000;

  typedef struct packed {
    logic [2:0] conf_id;
    logic [1:0] gain;
  } party_cfg_t;

  typedef struct packed {
    logic we;
    logic [3:0] party;
    logic [SAMPLE_W-1:0] data;
  } dm_write_t;

  function automatic logic [8:0] step_q8(input logic [1:0] code);
    case (code)
      2'h0: step_q8 = Q8_0DB;
      2'h1: step_q8 = Q8_3DB;
      2'h2: step_q8 = Q8_6DB;
      default: step_q8 = Q8_9DB;
    endcase
  endfunction

  function automatic logic is_party_addr(input logic [7:0] a);
    is_party_addr = (a >= PARTY_BASE_ADDR) && (a <= PARTY_LAST_ADDR);
  endfunction

  function automatic logic [3:0] party_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - PARTY_BASE_ADDR;
    party_index = d[3:0];
  endfunction

  function automatic logic conf_valid(input logic [2:0] id);
    conf_valid = (id != CONF_NONE) && (id <= CONF_LAST);
  endfunction

  function automatic logic [2:0] conf_slot(input logic [2:0] id);
    conf_slot = conf_valid(id) ? 3'(id - 3'h1) : 3'h0;
  endfunction

endpackage

// ---- logic/level_scaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module level_scaler (
  input wire logic signed [15:0] sample_i,
  input wire logic [1:0] code_i,
  output logic signed [15:0] scaled_o
);
  // factor is at most 1.0, so the product never outgrows the sample
  logic signed [9:0] factor;
  logic signed [25:0] product;
  assign factor = signed'({1'b0, conf_pkg::step_q8(code_i)});
  assign product = sample_i * factor;
  assign scaled_o = product[23:8];
endmodule
`default_nettype wire

// ---- logic/conference_party_control.sv ----
// How it works
// - up to fifteen parties spread over up to five conferences
// - id bits 7-5: 0 none, 1..5 conference, 7 clears all
// - start bit drops earlier members of that conference; reads back zero
// - outgoing gain field 0/-3/-6/-9 db applied to each party output
// - insertion tone write adds tone sample to conference outputs for tone time
// - insertion tone bit reads set in every member while tone runs
// - incoming channel attenuated by its connection memory high value
// - fifteen registers at 30..3e, reset value 00
// - with conference enable low, engine, tone timers and overflow latch held reset and no outputs; party registers kept
// - first overflow raises flag and latches id until read or reset
`timescale 1ns/1ps
`default_nettype none
module conference_party_control #(
  parameter logic [15:0] TONE_FRAMES = conf_pkg::TONE_FRAMES_DEFAULT
) (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic CONF_EN_I,
  input wire logic FRAME_I,
  input wire logic [7:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  output logic RDATA_VALID_O,
  input wire logic [14:0][15:0] IN_SAMPLE_I,
  input wire logic [14:0][1:0] IN_ATTEN_I,
  input wire logic [7:0] TONE_PTR_I,
  output logic [7:0] TONE_RD_ADDR_O,
  input wire logic [15:0] TONE_SAMPLE_I,
  output conf_pkg::dm_write_t DM_WR_O,
  output logic OVF_EVENT_O
);

  // ****************************************************************
  // host port decode
  // ****************************************************************
  conf_pkg::party_cfg_t cfg_q [conf_pkg::NUM_PARTIES];
  logic [15:0] tone_cnt_q [conf_pkg::NUM_CONFS];
  logic [conf_pkg::NUM_CONFS-1:0] tone_on;
  logic [2:0] ovf_id_q;

  wire wr_hit = WR_I && conf_pkg::is_party_addr(ADDR_I);
  wire rd_party = RD_I && conf_pkg::is_party_addr(ADDR_I);
  wire rd_ovf = RD_I && (ADDR_I == conf_pkg::OVF_STATUS_ADDR);
  wire [3:0] addr_idx = conf_pkg::party_index(ADDR_I);
  wire [2:0] wr_id = WDATA_I[conf_pkg::ID_MSB:conf_pkg::ID_LSB];
  wire [1:0] wr_gain = WDATA_I[conf_pkg::GAIN_MSB:conf_pkg::GAIN_LSB];
  wire wr_st = WDATA_I[conf_pkg::ST_BIT];
  wire wr_it = WDATA_I[conf_pkg::IT_BIT];
  wire [2:0] wr_slot = conf_pkg::conf_slot(wr_id);
  wire tone_start = wr_hit && wr_it && conf_pkg::conf_valid(wr_id);

  conf_pkg::party_cfg_t rd_cfg;
  wire [2:0] rd_slot;
  wire rd_tone;
  wire [7:0] rd_word;
  assign rd_cfg = cfg_q[addr_idx];
  assign rd_slot = conf_pkg::conf_slot(rd_cfg.conf_id);
  assign rd_tone = conf_pkg::conf_valid(rd_cfg.conf_id) && tone_on[rd_slot];
  // start bit is never stored, so it reads as zero
  assign rd_word = rd_party ? {rd_cfg.conf_id, 1'b0, 1'b0, rd_tone, rd_cfg.gain} :
                   rd_ovf ? {5'h00, ovf_id_q} : conf_pkg::READ_ZERO;

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      RDATA_O <= conf_pkg::READ_ZERO;
      RDATA_VALID_O <= 1'b0;
    end else begin
      RDATA_VALID_O <= RD_I;
      if (RD_I) begin
        RDATA_O <= rd_word;
      end
    end
  end

  // ****************************************************************
  // party registers
  // ****************************************************************
  always_ff @(posedge REF_CLK_I) begin
    for (int i = 0; i < conf_pkg::NUM_PARTIES; i++) begin
      if (SRST_I) begin
        // only the stored fields of the reset word are kept, start and tone bits are not held
        cfg_q[i].conf_id <= conf_pkg::PARTY_RESET[conf_pkg::ID_MSB:conf_pkg::ID_LSB];
        cfg_q[i].gain <= conf_pkg::PARTY_RESET[conf_pkg::GAIN_MSB:conf_pkg::GAIN_LSB];
      end else if (wr_hit) begin
        if (4'(i) == addr_idx) begin
          cfg_q[i].conf_id <= (wr_id == conf_pkg::CONF_CLEAR_ALL) ? conf_pkg::CONF_NONE : wr_id;
          cfg_q[i].gain <= wr_gain;
        end else if (wr_id == conf_pkg::CONF_CLEAR_ALL) begin
          cfg_q[i].conf_id <= conf_pkg::CONF_NONE;
        end else if (wr_st && conf_pkg::conf_valid(wr_id) && cfg_q[i].conf_id == wr_id) begin
          cfg_q[i].conf_id <= conf_pkg::CONF_NONE;
        end
      end
    end
  end

  // ****************************************************************
  // insertion tone timers, one per conference
  // ****************************************************************
  always_ff @(posedge REF_CLK_I) begin
    for (int c = 0; c < conf_pkg::NUM_CONFS; c++) begin
      if (SRST_I || !CONF_EN_I) begin
        tone_cnt_q[c] <= 16'h0000;
      end else if (tone_start && wr_slot == 3'(c)) begin
        tone_cnt_q[c] <= TONE_FRAMES;
      end else if (FRAME_I && tone_cnt_q[c] != 16'h0000) begin
        tone_cnt_q[c] <= tone_cnt_q[c] - 16'h0001;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < conf_pkg::NUM_CONFS; c++) begin
      tone_on[c] = (tone_cnt_q[c] != 16'h0000);
    end
  end

  // ****************************************************************
  // mixing engine: sum pass, then one output per conference member
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_SUM, ST_EMIT} eng_state_t;
  eng_state_t state_q;
  logic [3:0] idx_q;
  logic signed [conf_pkg::SUM_W-1:0] sum_q [conf_pkg::NUM_CONFS];
  logic signed [15:0] att_q [conf_pkg::NUM_PARTIES];
  logic signed [15:0] tone_smp_q;

  conf_pkg::party_cfg_t cur_cfg;
  wire [2:0] cur_slot;
  wire cur_member;
  wire last_idx = (idx_q == 4'(conf_pkg::NUM_PARTIES - 1));
  wire signed [15:0] att_w;
  wire signed [15:0] gained_w;
  wire signed [conf_pkg::SUM_W-1:0] total_w;
  wire signed [15:0] sat_w;
  wire sat_hit;
  wire ovf_w;

  assign cur_cfg = cfg_q[idx_q];
  assign cur_slot = conf_pkg::conf_slot(cur_cfg.conf_id);
  assign cur_member = conf_pkg::conf_valid(cur_cfg.conf_id);

  level_scaler in_scaler (
    .sample_i(signed'(IN_SAMPLE_I[idx_q])),
    .code_i(IN_ATTEN_I[idx_q]),
    .scaled_o(att_w)
  );

  // own input is taken back out so a party never hears itself
  assign total_w = sum_q[cur_slot] - conf_pkg::SUM_W'(att_q[idx_q]) +
                   (tone_on[cur_slot] ? conf_pkg::SUM_W'(tone_smp_q) : '0);
  assign sat_hit = (total_w > conf_pkg::SAT_MAX) || (total_w < conf_pkg::SAT_MIN);
  assign sat_w = (total_w > conf_pkg::SAT_MAX) ? conf_pkg::SAT_MAX[15:0] :
                 (total_w < conf_pkg::SAT_MIN) ? conf_pkg::SAT_MIN[15:0] : total_w[15:0];
  assign ovf_w = (state_q == ST_EMIT) && cur_member && sat_hit;

  level_scaler out_scaler (
    .sample_i(sat_w),
    .code_i(cur_cfg.gain),
    .scaled_o(gained_w)
  );

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || !CONF_EN_I) begin
      state_q <= ST_IDLE;
      idx_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (FRAME_I) begin
            state_q <= ST_SUM;
          end
          idx_q <= 4'h0;
        end
        ST_SUM: begin
          idx_q <= last_idx ? 4'h0 : idx_q + 4'h1;
          if (last_idx) begin
            state_q <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          idx_q <= last_idx ? 4'h0 : idx_q + 4'h1;
          if (last_idx) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (state_q == ST_IDLE) begin
      for (int c = 0; c < conf_pkg::NUM_CONFS; c++) begin
        sum_q[c] <= '0;
      end
      if (FRAME_I) begin
        tone_smp_q <= signed'(TONE_SAMPLE_I);
      end
    end else if (state_q == ST_SUM) begin
      att_q[idx_q] <= att_w;
      if (cur_member) begin
        sum_q[cur_slot] <= sum_q[cur_slot] + conf_pkg::SUM_W'(att_w);
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || !CONF_EN_I) begin
      DM_WR_O <= '0;
      TONE_RD_ADDR_O <= 8'h00;
    end else begin
      TONE_RD_ADDR_O <= TONE_PTR_I;
      DM_WR_O.we <= (state_q == ST_EMIT) && cur_member;
      DM_WR_O.party <= idx_q;
      DM_WR_O.data <= gained_w;
    end
  end

  // ****************************************************************
  // overflow latch
  // ****************************************************************
  // a new overflow in the cycle of the clearing read is kept, not lost
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || !CONF_EN_I) begin
      ovf_id_q <= conf_pkg::CONF_NONE;
      OVF_EVENT_O <= 1'b0;
    end else begin
      OVF_EVENT_O <= ovf_w && (ovf_id_q == conf_pkg::CONF_NONE || rd_ovf);
      if (ovf_w && (ovf_id_q == conf_pkg::CONF_NONE || rd_ovf)) begin
        ovf_id_q <= cur_cfg.conf_id;
      end else if (rd_ovf) begin
        ovf_id_q <= conf_pkg::CONF_NONE;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  start_drops_a: assert property (wr_hit && wr_st && conf_pkg::conf_valid(wr_id) && wr_id != conf_pkg::CONF_CLEAR_ALL
    |=> cfg_q[$past(addr_idx)].conf_id == $past(wr_id) && cur_member_count_other($past(wr_id), $past(addr_idx)) == 0)
    else $error("start bit left other parties in the conference");
  clear_all_a: assert property (wr_hit && wr_id == conf_pkg::CONF_CLEAR_ALL |=> members_total() == 0)
    else $error("clear all left a party in a conference");
  reset_value_a: assert property (disable iff (1'b0) $past(SRST_I) |-> cfg_q[0] == '0 && cfg_q[14] == '0)
    else $error("party register not zero after reset");
  disabled_quiet_a: assert property (!CONF_EN_I |=> !DM_WR_O.we [*2])
    else $error("output written while conference disabled");
  ovf_hold_a: assert property (ovf_id_q != conf_pkg::CONF_NONE && !rd_ovf && CONF_EN_I |=> $stable(ovf_id_q))
    else $error("overflow id changed before read");
  ovf_flag_a: assert property (OVF_EVENT_O |-> conf_pkg::conf_valid(ovf_id_q))
    else $error("overflow flag without latched id");
  tone_read_a: assert property (rd_party && rd_tone |=> RDATA_VALID_O && RDATA_O[conf_pkg::IT_BIT])
    else $error("tone bit not shown during tone");
  start_zero_a: assert property (RDATA_VALID_O |-> !RDATA_O[conf_pkg::ST_BIT])
    else $error("start bit read back set");
  tone_load_a: assert property (tone_start && CONF_EN_I |=> tone_cnt_q[$past(wr_slot)] == TONE_FRAMES)
    else $error("tone timer not loaded");
  member_out_a: assert property (DM_WR_O.we |-> conf_pkg::conf_valid(cfg_q[DM_WR_O.party].conf_id)
    || $past(wr_hit)) else $error("output for party outside any conference");
  // dropping the enable mid-pass legally aborts the pass, so it also ends this check
  frame_len_a: assert property (disable iff (SRST_I || !CONF_EN_I)
    state_q == ST_IDLE ##1 state_q == ST_SUM |-> ##15 state_q == ST_EMIT)
    else $error("sum pass length wrong");
  read_answer_a: assert property (RD_I |=> RDATA_VALID_O)
    else $error("read strobe not answered");

  cov_overflow: cover property (OVF_EVENT_O);
  cov_tone: cover property (tone_start ##1 DM_WR_O.we);
  cov_start: cover property (wr_hit && wr_st);
  cov_clear: cover property (wr_hit && wr_id == conf_pkg::CONF_CLEAR_ALL);
  cov_disable: cover property (!CONF_EN_I ##1 CONF_EN_I);

  function automatic int cur_member_count_other(input logic [2:0] id, input logic [3:0] keep);
    int n;
    n = 0;
    for (int i = 0; i < conf_pkg::NUM_PARTIES; i++) begin
      if (4'(i) != keep && cfg_q[i].conf_id == id) begin
        n++;
      end
    end
    return n;
  endfunction

  function automatic int members_total();
    int n;
    n = 0;
    for (int i = 0; i < conf_pkg::NUM_PARTIES; i++) begin
      if (cfg_q[i].conf_id != conf_pkg::CONF_NONE) begin
        n++;
      end
    end
    return n;
  endfunction

endmodule
`default_nettype wire

// ---- tb/tone_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tone_source_model #(
  parameter logic [7:0] PTR = 8'h05
) (
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] ptr_o,
  output logic [15:0] sample_o
);
  // ****************************************************************
  // tone pointer and tone memory
  // ****************************************************************
  // pointer is loaded from reset on, before any tone is asked for
  assign ptr_o = PTR;
  // contents follow the address so a stale address shows a wrong sample
  assign sample_o = {4'h0, rd_addr_i[3:0], 8'h00};
endmodule
`default_nettype wire

// ---- tb/conference_party_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module conference_party_control_bench;
  localparam logic [7:0] TONE_PTR = 8'h05;
  logic clk, srst, en, frame, wr, rd, rvalid, ovf, chk;
  logic [7:0] addr, wdata, rdata, ptr, trd;
  logic [14:0][15:0] in_s;
  logic [14:0][1:0] in_a;
  logic [15:0] tsamp;
  conf_pkg::dm_write_t dm;
  logic [19:0] dm_q[$];
  logic [7:0] rd_q[$];
  logic [2:0] cid[15];
  logic [1:0] gn[15];
  logic tone_on[5];
  int err_count, num_checks, ovf_seen, k;
  int fq[4] = '{256, 181, 128, 91};

  conference_party_control #(.TONE_FRAMES(16'h0004)) u_conference_party_control (
    .REF_CLK_I(clk), .SRST_I(srst), .CONF_EN_I(en), .FRAME_I(frame), .ADDR_I(addr),
    .WR_I(wr), .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata), .RDATA_VALID_O(rvalid),
    .IN_SAMPLE_I(in_s), .IN_ATTEN_I(in_a), .TONE_PTR_I(ptr), .TONE_RD_ADDR_O(trd),
    .TONE_SAMPLE_I(tsamp), .DM_WR_O(dm), .OVF_EVENT_O(ovf));
  tone_source_model #(.PTR(TONE_PTR)) u_tone_source_model (
    .rd_addr_i(trd), .ptr_o(ptr), .sample_o(tsamp));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic cmp(input logic [19:0] e, input logic [19:0] a);
    num_checks++;
    if (a !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task automatic close_out();
    if (dm_q.size() != 0 || rd_q.size() != 0) err_count++;
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk) wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    @(negedge clk);
  endtask

  task automatic cfg(input int p, input logic [7:0] v);
    cid[p] = v[7:5];
    gn[p] = v[1:0];
    wr_reg(8'h30 + 8'(p), v);
  endtask

  // expected output per member: gain(sat(others attenuated + tone)), in party order
  task automatic run_frame(input logic c);
    int s, t;
    for (int p = 0; p < 15; p++) begin
      if (c && en && cid[p] >= 3'h1 && cid[p] <= 3'h5) begin
        s = tone_on[cid[p] - 3'h1] ? int'(TONE_PTR[3:0]) * 256 : 0;
        for (int j = 0; j < 15; j++)
          if (j != p && cid[j] == cid[p]) s += ($signed(in_s[j]) * fq[in_a[j]]) >>> 8;
        if (s > 32767) s = 32767;
        if (s < -32768) s = -32768;
        t = (s * fq[gn[p]]) >>> 8;
        dm_q.push_back({4'(p), 16'(t)});
      end
    end
    chk = c;
    @(negedge clk) frame = 1'b1;
    @(negedge clk) frame = 1'b0;
    repeat (34) @(negedge clk);
  endtask

  // ****************************************************************
  // clock, monitor, watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // outputs are registered, so the falling edge sees each one-cycle pulse once
  always @(negedge clk) begin
    if (ovf === 1'b1) ovf_seen++;
    if (dm.we === 1'b1 && chk) cmp(dm_q.size() ? dm_q.pop_front() : 20'hfffff, {dm.party, dm.data});
    if (rvalid === 1'b1) cmp(rd_q.size() ? {12'h0, rd_q.pop_front()} : 20'hfffff, {12'h0, rdata});
  end

  initial begin
    #200us;
    err_count++;
    close_out();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    srst = 1'b1;
    en = 1'b1;
    frame = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    in_s = '0;
    in_a = '0;
    chk = 1'b0;
    for (int p = 0; p < 15; p++) cid[p] = 3'h0;
    for (int p = 0; p < 15; p++) gn[p] = 2'h0;
    for (int c = 0; c < 5; c++) tone_on[c] = 1'b0;
    k = $urandom(69);
    repeat (2) @(negedge clk);
    srst = 1'b0;
    for (int p = 0; p < 15; p++) rd_reg(8'h30 + 8'(p), 8'h00);
    rd_reg(8'h3f, 8'h00);
    rd_reg(8'h08, 8'h00);
    // samples are multiples of 256 so every scaling step is exact
    for (int m = 0; m < 2; m++) begin
      for (int p = 0; p < 15; p++) begin
        in_s[p] = 16'((int'($urandom % 16) - 8) * 256);
        in_a[p] = m ? 2'h0 : 2'($urandom);
        k = $urandom % 6;
        cfg(p, {3'(k), 3'h0, m ? 2'($urandom) : 2'h0});
      end
      run_frame(1'b1);
    end
    cfg(1, 8'h20);
    cfg(2, 8'h20);
    cfg(0, 8'h28);
    rd_reg(8'h30, 8'h20);
    rd_reg(8'h32, 8'h00);
    cfg(3, 8'he0);
    for (int p = 0; p < 15; p++) cid[p] = 3'h0;
    rd_reg(8'h30, 8'h00);
    in_s = '0;
    in_a = '0;
    in_s[0] = 16'h0100;
    in_s[1] = 16'h0200;
    cfg(0, 8'h40);
    cfg(1, 8'h44);
    tone_on[1] = 1'b1;
    rd_reg(8'h30, 8'h44);
    run_frame(1'b1);
    repeat (4) run_frame(1'b0);
    tone_on[1] = 1'b0;
    rd_reg(8'h31, 8'h40);
    for (int p = 2; p < 5; p++) in_s[p] = 16'h7f00;
    for (int p = 2; p < 5; p++) cfg(p, 8'h60);
    ovf_seen = 0;
    run_frame(1'b1);
    cmp(20'h00001, 20'(ovf_seen));
    rd_reg(8'h08, 8'h03);
    rd_reg(8'h08, 8'h00);
    en = 1'b0;
    run_frame(1'b1);
    en = 1'b1;
    // second reset in mid-run: party 0 held 40 before it
    srst = 1'b1;
    @(negedge clk);
    @(negedge clk) srst = 1'b0;
    rd_reg(8'h30, 8'h00);
    rd_reg(8'h08, 8'h00);
    cmp({12'h0, TONE_PTR}, {12'h0, trd});
    close_out();
  end
endmodule
`default_nettype wire
